/* File: ccp_output_shutdown_control.sv */
`timescale 1ns/1ps
`default_nettype none
module ccp_output_shutdown_control
  import ccp_pkg::*;
#(
  parameter bit MULTI_OUTPUT = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire ccp_wb_req_t wb_req_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire ccp_src_t    src_i,
  input  wire logic        pwm_i,
  input  wire logic        timebase_reset_i,
  input  wire logic        timer_tick_i,
  input  wire logic        trigger_i,
  input  wire logic        compare_event_i,
  input  wire logic        capture_pin_i,
  input  wire logic        capture_overflow_i,
  input  wire logic        capture_not_empty_i,
  output ccp_pins_t        pins_o,
  output logic             capture_event_o,
  output logic             shutdown_o,
  output logic             trigger_active_o
);
  localparam logic [31:0] CON3_MASK = MULTI_OUTPUT ? CCP_CON3_MASK_MULTI : CCP_CON3_MASK_SINGLE;
  localparam logic [5:0]  PIN_PRESENT = MULTI_OUTPUT ? 6'h3F : 6'h01;

  logic [31:0] shutdown_gate_control;
  logic [31:0] output_shaping_control;
  logic [31:0] aux_control;
  logic        capture_input_disable;
  logic        compare_event_flag;
  logic        capture_overflow_flag;

  logic        shutdown_gate_mode;
  logic        software_shutdown_force;
  logic [7:0]  shutdown_source_enables;
  logic        output_trigger_hold;
  logic [2:0]  one_shot_stretch;
  logic [2:0]  output_mode_select;
  logic        polarity_group_ace;
  logic        polarity_group_bdf;
  logic [1:0]  shutdown_state_ace;
  logic [1:0]  shutdown_state_bdf;
  logic [5:0]  dead_time_count;
  logic        triggered_mode_enable;

  assign shutdown_gate_mode      = shutdown_gate_control[CCP_GM_BIT];
  assign software_shutdown_force = shutdown_gate_control[CCP_SWF_BIT];
  assign shutdown_source_enables = shutdown_gate_control[CCP_SRC_LSB +: 8];
  assign output_trigger_hold     = output_shaping_control[CCP_HOLD_BIT];
  assign one_shot_stretch        = output_shaping_control[CCP_STRETCH_LSB +: 3];
  assign output_mode_select      = output_shaping_control[CCP_MODE_LSB +: 3];
  assign polarity_group_ace      = output_shaping_control[CCP_POL_ACE_BIT];
  assign polarity_group_bdf      = output_shaping_control[CCP_POL_BDF_BIT];
  assign shutdown_state_ace      = output_shaping_control[CCP_PSS_ACE_LSB +: 2];
  assign shutdown_state_bdf      = output_shaping_control[CCP_PSS_BDF_LSB +: 2];
  assign dead_time_count         = output_shaping_control[CCP_DEAD_LSB +: 6];
  assign triggered_mode_enable   = aux_control[CCP_TRIG_MODE_BIT];

  // wishbone slave
  logic        bus_access;
  logic        bus_write;
  logic        hit_con2;
  logic        hit_con3;
  logic        hit_stat;
  logic        hit_aux;
  logic        stat_wr;
  logic        capture_force_wr;
  logic        trigger_force_wr;
  logic        stat_read_q;
  logic [31:0] byte_mask;
  logic [31:0] next_rdata;

  assign bus_access = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  // write lands on the edge at which the master samples ack high
  assign bus_write  = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_ack_o;
  assign hit_con2   = wb_req_i.adr == CCP_OFS_SHUTDOWN_GATE;
  assign hit_con3   = wb_req_i.adr == CCP_OFS_OUTPUT_SHAPING;
  assign hit_stat   = wb_req_i.adr == CCP_OFS_STATUS;
  assign hit_aux    = wb_req_i.adr == CCP_OFS_AUX_CONTROL;
  assign byte_mask  = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                       {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
  assign stat_wr    = bus_write && hit_stat && wb_req_i.sel[0];
  // no storage behind these bits: a one fires the event
  assign capture_force_wr = stat_wr && wb_req_i.dat[CCP_CAPF_BIT]; // [R18]
  assign trigger_force_wr = stat_wr && wb_req_i.dat[CCP_TRGF_BIT]; // [R18]

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wmask);
    merge = (old & ~(wmask & byte_mask)) | (wb_req_i.dat & wmask & byte_mask);
  endfunction : merge

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
      stat_read_q <= 1'b0;
    end else begin
      wb_ack_o    <= bus_access;
      stat_read_q <= bus_access && !wb_req_i.we && hit_stat;
      if (bus_access && !wb_req_i.we) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_con2) begin
      next_rdata = shutdown_gate_control;
    end else if (hit_con3) begin
      next_rdata = output_shaping_control;
    end else if (hit_aux) begin
      next_rdata = aux_control;
    end else if (hit_stat) begin
      next_rdata[CCP_CMP_EVT_BIT] = compare_event_flag;
      next_rdata[CCP_CAP_DIS_BIT] = capture_input_disable;
      next_rdata[CCP_OVF_BIT]     = capture_overflow_flag;
      next_rdata[CCP_BNE_BIT]     = capture_not_empty_i; // [R17]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shutdown_gate_control <= CCP_CON2_RESET;
    end else if (bus_write && hit_con2) begin
      shutdown_gate_control <= merge(shutdown_gate_control, CCP_CON2_MASK);
    end
  end

  // group-two fields and dead time have no storage in single-output builds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_shaping_control <= CCP_CON3_RESET;
    end else if (bus_write && hit_con3) begin
      output_shaping_control <= merge(output_shaping_control, CON3_MASK); // [R13]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_control <= CCP_AUX_RESET;
    end else if (bus_write && hit_aux) begin
      aux_control <= merge(aux_control, CCP_AUX_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_input_disable <= 1'b0;
    end else if (stat_wr) begin
      capture_input_disable <= wb_req_i.dat[CCP_CAP_DIS_BIT];
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_event_flag <= 1'b0;
    end else if (compare_event_i) begin
      compare_event_flag <= 1'b1; // [R14]
    end else if (stat_wr && !wb_req_i.dat[CCP_CMP_EVT_BIT]) begin
      compare_event_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_overflow_flag <= 1'b0;
    end else if (capture_overflow_i) begin
      capture_overflow_flag <= 1'b1; // [R16]
    end else if (stat_wr && !wb_req_i.dat[CCP_OVF_BIT]) begin
      capture_overflow_flag <= 1'b0;
    end
  end

  // capture edge detection
  logic capture_pin_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_pin_q   <= 1'b0;
      capture_event_o <= 1'b0;
    end else begin
      capture_pin_q   <= capture_pin_i;
      capture_event_o <= (capture_pin_i && !capture_pin_q && !capture_input_disable) // [R15]
                         || capture_force_wr; // [R18]
    end
  end

  // shutdown sources and timing
  logic [7:0] source_vector;
  logic       shutdown_request;

  assign source_vector = {src_i.fault_pin_second, // [R4]
                          src_i.fault_pin_first,  // [R4]
                          src_i.logic_cell_one,   // [R5]
                          src_i.sibling_output,   // [R6]
                          src_i.comparator};      // [R7]
  assign shutdown_request = (|(source_vector & shutdown_source_enables)) // [R3]
                            || software_shutdown_force; // [R2]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shutdown_o <= 1'b0;
    end else if (!shutdown_gate_mode || timebase_reset_i) begin
      shutdown_o <= shutdown_request; // [R1]
    end
  end

  // one-shot trigger stretch
  logic       trigger_event;
  logic       trigger_hold;
  logic [2:0] stretch_count;

  assign trigger_event = trigger_i || trigger_force_wr;
  assign trigger_hold  = triggered_mode_enable && output_trigger_hold && !trigger_active_o; // [R8]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trigger_active_o <= 1'b0;
      stretch_count    <= 3'h0;
    end else if (trigger_event) begin
      trigger_active_o <= 1'b1;
      stretch_count    <= one_shot_stretch; // [R9]
    end else if (trigger_active_o && timer_tick_i) begin
      if (stretch_count == 3'h0) begin
        trigger_active_o <= 1'b0; // [R9]
      end else begin
        stretch_count <= stretch_count - 3'h1;
      end
    end
  end

  // output mode steering
  logic       push_phase;
  logic [2:0] scan_index;
  logic [5:0] raw;
  logic [5:2] raw_q;
  logic       delayed_a;
  logic       delayed_b;
  logic [5:0] delayed;
  logic [5:0] dead_eff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      push_phase <= 1'b0;
      scan_index <= 3'h0;
    end else if (timebase_reset_i) begin
      push_phase <= !push_phase;
      scan_index <= (scan_index == CCP_SCAN_LAST) ? 3'h0 : scan_index + 3'h1;
    end
  end

  always_comb begin
    raw = 6'h00;
    unique case (output_mode_select) // [R10]
      CCP_MODE_STEER: raw = {6{pwm_i}};
      CCP_MODE_PUSH:  raw[1:0] = push_phase ? {pwm_i, 1'b0} : {1'b0, pwm_i};
      CCP_MODE_HALF:  raw[1:0] = {!pwm_i, pwm_i};
      CCP_MODE_REV: begin
        raw[2] = 1'b1;
        raw[1] = pwm_i;
      end
      CCP_MODE_FWD: begin
        raw[0] = 1'b1;
        raw[3] = pwm_i;
      end
      CCP_MODE_SCAN:  raw = 6'(pwm_i) << scan_index;
      default:        raw = 6'h00;
    endcase
  end

  // dead time only in complementary modes
  assign dead_eff = (output_mode_select == CCP_MODE_HALF || output_mode_select == CCP_MODE_PUSH)
                    ? dead_time_count : 6'h00; // [R19]

  ccp_dead_time u_dead_a (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (raw[0]),
    .dead_i  (dead_eff),
    .level_o (delayed_a)
  );

  ccp_dead_time u_dead_b (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (raw[1]),
    .dead_i  (dead_eff),
    .level_o (delayed_b)
  );

  // keeps the other pins aligned with the dead-time stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_q <= 4'h0;
    end else begin
      raw_q <= raw[5:2];
    end
  end

  assign delayed = {raw_q, delayed_b, delayed_a};

  // polarity, shutdown state and pin drive
  logic [5:0] pin_pol;
  logic [5:0] pss_drive;
  logic [5:0] pss_level;
  ccp_pins_t  next_pins;

  assign pin_pol   = {3{polarity_group_bdf, polarity_group_ace}}; // [R11] [R12]
  assign pss_drive = {3{shutdown_state_bdf[CCP_PSS_DRIVE_BIT], shutdown_state_ace[CCP_PSS_DRIVE_BIT]}};
  assign pss_level = {3{shutdown_state_bdf[CCP_PSS_LEVEL_BIT], shutdown_state_ace[CCP_PSS_LEVEL_BIT]}};

  always_comb begin
    next_pins = CCP_PINS_RESET;
    for (int i = 0; i < CCP_PIN_COUNT; i++) begin
      if (!PIN_PRESENT[i]) begin
        next_pins.oe_n[i] = 1'b1; // [R13]
      end else if (shutdown_o) begin
        next_pins.oe_n[i]  = !pss_drive[i]; // [R20]
        next_pins.level[i] = pss_drive[i] && (pss_level[i] ^ pin_pol[i]); // [R20]
      end else if (trigger_hold) begin
        next_pins.oe_n[i] = 1'b1; // [R8]
      end else begin
        next_pins.oe_n[i]  = 1'b0;
        next_pins.level[i] = delayed[i] ^ pin_pol[i]; // [R11] [R12]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_o <= CCP_PINS_RESET;
    end else begin
      pins_o <= next_pins;
    end
  end

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  a_shut_immediate: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    !shutdown_gate_mode && shutdown_request |=> shutdown_o)
    else $error("immediate shutdown not applied");

  a_shut_deferred: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    shutdown_gate_mode && !timebase_reset_i |=> $stable(shutdown_o))
    else $error("gated shutdown changed off the time base reset");

  a_soft_force: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    software_shutdown_force && (!shutdown_gate_mode || timebase_reset_i) |=> shutdown_o)
    else $error("software force did not shut down");

  a_source_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (source_vector & shutdown_source_enables) == 8'h00 && !software_shutdown_force
    && !shutdown_gate_mode |=> !shutdown_o)
    else $error("shutdown without an enabled source");

  a_half_bridge: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    output_mode_select == CCP_MODE_HALF |-> raw[1] == !raw[0] && raw[5:2] == 4'h0)
    else $error("half-bridge outputs not complementary");

  a_trig_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    trigger_hold && !shutdown_o |=> pins_o.oe_n == 6'h3F)
    else $error("pins driven while waiting for trigger");

  a_stretch_load: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    trigger_event |=> trigger_active_o && stretch_count == $past(one_shot_stretch))
    else $error("one-shot stretch not loaded");

  a_stretch_end: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    trigger_active_o && timer_tick_i && stretch_count == 3'h0 && !trigger_event
    |=> !trigger_active_o)
    else $error("one-shot outlived its stretch");

  a_polarity_ace: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    !shutdown_o && !trigger_hold |=> pins_o.level[0] == ($past(delayed_a) ^ $past(polarity_group_ace)))
    else $error("pin A polarity wrong");

  a_polarity_bdf: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    MULTI_OUTPUT && !shutdown_o && !trigger_hold
    |=> pins_o.level[1] == ($past(delayed_b) ^ $past(polarity_group_bdf)))
    else $error("pin B polarity wrong");

  a_single_absent: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    !MULTI_OUTPUT |-> pins_o.oe_n[5:1] == 5'h1F && output_mode_select == 3'h0)
    else $error("extra outputs present in single-output build");

  a_compare_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    compare_event_i |=> compare_event_flag)
    else $error("compare event flag not set");

  a_capture_off: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
    capture_input_disable && !capture_force_wr |=> !capture_event_o)
    else $error("capture event while disabled");

  a_overflow_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    capture_overflow_i |=> capture_overflow_flag)
    else $error("overflow flag not set");

  a_not_empty: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    wb_ack_o && stat_read_q |-> wb_dat_o[CCP_BNE_BIT] == $past(capture_not_empty_i))
    else $error("buffer status read back wrong");

  a_force_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    wb_ack_o && stat_read_q |-> !wb_dat_o[CCP_CAPF_BIT] && !wb_dat_o[CCP_TRGF_BIT])
    else $error("event bit read as one");
endmodule : ccp_output_shutdown_control
`default_nettype wire

/* File: ccp_pkg.sv */
// Overview of operation
// [R1] Gate mode set defers shutdown to next time base reset; clear applies it at once.
// [R2] Software force bit forces shutdown or gating, still timed by gate mode.
// [R3] Each enable bit lets its source shut down; any enabled source asserting shuts down.
// [R4] Enable bit 7 routes second fault pin, bit 6 the first fault pin.
// [R5] Enable bit 5 selects the instance's logic cell output as a source.
// [R6] Enable bits 4 and 3 select outputs of designated sibling modules.
// [R7] Enable bits 2, 1, 0 select comparators 3, 2 and 1.
// [R8] Triggered mode with hold bit leaves enabled pins undriven until a trigger.
// [R9] Stretch field n makes a one-shot trigger last n+1 timer count periods.
// [R10] Mode field picks steerable, push-pull, half-bridge, brush reverse, forward or scan.
// [R11] Pins A, C, E are active-low when their polarity bit is set.
// [R12] Pins B, D, F are active-low when their polarity bit is set.
// [R13] Mode, group-two controls, dead time and extra pins exist in multi-output instances only.
// [R14] A single edge compare event sets a status flag.
// [R15] Capture-disable bit set stops capture pin edges from making capture events.
// [R16] Capture buffer overflow sets an overflow status flag.
// [R17] Buffer-not-empty flag reads set while captured data is available.
// [R18] Event bits without storage read zero; writing one fires the event.
// [R19] Dead-time field delays complementary rising edges in half-bridge and push-pull.
// [R20] Shutdown state fields choose inactive, active or undriven pins during shutdown.
package ccp_pkg;
  localparam logic [7:0]  CCP_OFS_SHUTDOWN_GATE  = 8'h00;
  localparam logic [7:0]  CCP_OFS_OUTPUT_SHAPING = 8'h04;
  localparam logic [7:0]  CCP_OFS_STATUS         = 8'h08;
  localparam logic [7:0]  CCP_OFS_AUX_CONTROL    = 8'h0C;
  localparam int          CCP_GM_BIT             = 14;
  localparam int          CCP_SWF_BIT            = 12;
  localparam int          CCP_SRC_LSB            = 0;
  localparam int          CCP_HOLD_BIT           = 31;
  localparam int          CCP_STRETCH_LSB        = 28;
  localparam int          CCP_MODE_LSB           = 24;
  localparam int          CCP_POL_ACE_BIT        = 21;
  localparam int          CCP_POL_BDF_BIT        = 20;
  localparam int          CCP_PSS_ACE_LSB        = 18;
  localparam int          CCP_PSS_BDF_LSB        = 16;
  localparam int          CCP_DEAD_LSB           = 0;
  localparam int          CCP_TRGF_BIT           = 5;
  localparam int          CCP_CAPF_BIT           = 4;
  localparam int          CCP_CMP_EVT_BIT        = 3;
  localparam int          CCP_CAP_DIS_BIT        = 2;
  localparam int          CCP_OVF_BIT            = 1;
  localparam int          CCP_BNE_BIT            = 0;
  localparam int          CCP_TRIG_MODE_BIT      = 0;
  localparam int          CCP_PIN_COUNT          = 6;
  localparam int          CCP_PSS_DRIVE_BIT      = 1;
  localparam int          CCP_PSS_LEVEL_BIT      = 0;
  localparam logic [31:0] CCP_CON2_MASK          = 32'h0000_50FF;
  localparam logic [31:0] CCP_CON3_MASK_MULTI    = 32'hF73F_003F;
  localparam logic [31:0] CCP_CON3_MASK_SINGLE   = 32'hF02C_0000;
  localparam logic [31:0] CCP_AUX_MASK           = 32'h0000_0001;
  localparam logic [31:0] CCP_CON2_RESET         = 32'h0000_0000;
  localparam logic [31:0] CCP_CON3_RESET         = 32'h0000_0000;
  localparam logic [31:0] CCP_AUX_RESET          = 32'h0000_0000;
  localparam logic [2:0]  CCP_MODE_STEER         = 3'h0;
  localparam logic [2:0]  CCP_MODE_PUSH          = 3'h1;
  localparam logic [2:0]  CCP_MODE_HALF          = 3'h2;
  localparam logic [2:0]  CCP_MODE_REV           = 3'h4;
  localparam logic [2:0]  CCP_MODE_FWD           = 3'h5;
  localparam logic [2:0]  CCP_MODE_SCAN          = 3'h6;
  localparam logic [2:0]  CCP_SCAN_LAST          = 3'h5;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } ccp_wb_req_t;

  typedef struct packed {
    logic       fault_pin_second;
    logic       fault_pin_first;
    logic       logic_cell_one;
    logic [1:0] sibling_output;
    logic [2:0] comparator;
  } ccp_src_t;

  typedef struct packed {
    logic [5:0] level;
    logic [5:0] oe_n;
  } ccp_pins_t;

  localparam ccp_pins_t   CCP_PINS_RESET         = '{level: 6'h00, oe_n: 6'h3F};
endpackage : ccp_pkg

/* File: ccp_dead_time.sv */
`timescale 1ns/1ps
`default_nettype none
module ccp_dead_time
  import ccp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       level_i,
  input  wire logic [5:0] dead_i,
  output logic            level_o
);
  logic [5:0] count;

  // rising edge waits dead_i clocks, falling edge passes at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count   <= 6'h00;
      level_o <= 1'b0;
    end else if (!level_i) begin
      count   <= 6'h00;
      level_o <= 1'b0;
    end else if (count == dead_i) begin
      level_o <= 1'b1;
    end else begin
      count <= count + 6'h01;
    end
  end
endmodule : ccp_dead_time
`default_nettype wire

/* File: ccp_power_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ccp_power_stage_model
  import ccp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire ccp_pins_t  pins_i,
  input  wire logic [1:0] fault_cmd_i,
  output logic      [1:0] fault_o,
  output logic      [5:0] stage_o
);
  // fault comparators report one clock after the command
  always_ff @(posedge clk_i) begin
    fault_o <= fault_cmd_i;
  end
  // released gate inputs fall to the pull-down level
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      stage_o[i] = pins_i.oe_n[i] ? 1'b0 : pins_i.level[i];
    end
  end
endmodule : ccp_power_stage_model
`default_nettype wire

/* File: test_ccp_output_shutdown_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ccp_output_shutdown_control;
  import ccp_pkg::*;
  logic        clk_i, rst_i, pwm, tb_rst, tick, trig, cmp_ev, cap_pin, cap_ov, cap_ne;
  logic        ack, cap_ev, sd, tact;
  logic [31:0] rdat;
  logic [7:0]  en, s;
  logic [5:0]  lsrc, stage;
  logic [1:0]  fcmd, fault;
  ccp_wb_req_t req;
  ccp_pins_t   pins;
  int          fails, checked, cycles, caps;
  logic [31:0] expq[$];

  ccp_output_shutdown_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(rdat),
    .wb_ack_o(ack), .src_i({fault, lsrc}), .pwm_i(pwm), .timebase_reset_i(tb_rst), .timer_tick_i(tick),
    .trigger_i(trig), .compare_event_i(cmp_ev), .capture_pin_i(cap_pin), .capture_overflow_i(cap_ov),
    .capture_not_empty_i(cap_ne), .pins_o(pins), .capture_event_o(cap_ev), .shutdown_o(sd),
    .trigger_active_o(tact));
  ccp_power_stage_model stage_u (.clk_i(clk_i), .pins_i(pins), .fault_cmd_i(fcmd), .fault_o(fault),
    .stage_o(stage));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // read: d is the expected word, noted before the request
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) expq.push_back(d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, 4'hF, a, w ? d : 32'h0000_0000};
    do @(posedge clk_i); while (ack !== 1'b1);
    req <= '0;
  endtask : wb

  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask : w

  task automatic report_and_stop;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (ack === 1'b1 && req.we === 1'b0) chk("read data", expq.pop_front(), rdat);
    if (cap_ev === 1'b1) caps <= caps + 1;
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    {pwm, tb_rst, tick, trig, cmp_ev, cap_pin, cap_ov, cap_ne, lsrc, fcmd} = '0;
    req = '0;
    rst_i = 1'b1;
    void'($urandom(10));
    w(20);
    rst_i <= 1'b0;
    w(1);
    foreach (en[i]) wb(1'b0, 8'h00 + 8'(i * 4), 32'h0000_0000);
    wb(1'b1, 8'h00, '1);
    wb(1'b0, 8'h00, CCP_CON2_MASK);
    wb(1'b1, 8'h04, '1);
    wb(1'b0, 8'h04, CCP_CON3_MASK_MULTI);
    wb(1'b1, 8'h04, 32'h0000_0000);
    $display("done registers");
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, 8'h00, 32'h0000_0001 << i);
      {fcmd, lsrc} <= 8'h01 << i;
      w(3);
      chk("shutdown own", 32'h1, sd);
      {fcmd, lsrc} <= ~(8'h01 << i);
      w(3);
      chk("shutdown other", 32'h0, sd);
    end
    repeat (12) begin
      en = 8'($urandom);
      s = 8'($urandom);
      wb(1'b1, 8'h00, {24'h0, en});
      {fcmd, lsrc} <= s;
      w(3);
      chk("shutdown random", {31'h0, |(en & s)}, sd);
    end
    $display("done sources");
    {fcmd, lsrc} <= 8'h00;
    wb(1'b1, 8'h00, 32'h0000_0000);
    w(2);
    wb(1'b1, 8'h00, 32'h0000_4001);
    {fcmd, lsrc} <= 8'h01;
    w(3);
    chk("gated wait", 32'h0, sd);
    tb_rst <= 1'b1;
    w(1);
    tb_rst <= 1'b0;
    w(1);
    chk("gated applied", 32'h1, sd);
    {fcmd, lsrc} <= 8'h00;
    wb(1'b1, 8'h00, 32'h0000_0000);
    wb(1'b1, 8'h04, 32'h000C_0000);
    wb(1'b1, 8'h00, 32'h0000_1000);
    w(3);
    chk("forced", 32'h1, sd);
    chk("pin a state", 32'h1, stage[0]);
    wb(1'b1, 8'h00, 32'h0000_0000);
    w(3);
    chk("released", 32'h0, sd);
    $display("done shutdown");
    wb(1'b1, 8'h04, 32'h0020_0000);
    w(4);
    chk("pins ace low", 32'h1, stage[1:0]);
    wb(1'b1, 8'h04, 32'h0010_0000);
    w(4);
    chk("pins bdf low", 32'h2, stage[1:0]);
    wb(1'b1, 8'h04, 32'h0200_0000);
    w(4);
    chk("half bridge", 32'h2, stage[1:0]);
    pwm <= 1'b1;
    wb(1'b1, 8'h04, 32'h0400_0000);
    w(4);
    chk("brush reverse", 32'h06, stage);
    wb(1'b1, 8'h04, 32'h0500_0000);
    w(4);
    chk("brush forward", 32'h09, stage);
    // one time base reset so far: scan sits on pin B
    wb(1'b1, 8'h04, 32'h0600_0000);
    w(4);
    chk("scan first", 32'h02, stage);
    tb_rst <= 1'b1;
    w(1);
    tb_rst <= 1'b0;
    w(3);
    chk("scan next", 32'h04, stage);
    // two time base resets: push-pull phase back on pin A
    wb(1'b1, 8'h04, 32'h0100_0000);
    w(4);
    chk("push pull", 32'h01, stage);
    wb(1'b1, 8'h04, 32'h0200_0003);
    w(4);
    pwm <= 1'b0;
    w(5);
    chk("dead time wait", 32'h00, stage);
    w(1);
    chk("dead time end", 32'h02, stage);
    $display("done outputs");
    wb(1'b1, 8'h04, 32'h2000_0000);
    trig <= 1'b1;
    w(1);
    trig <= 1'b0;
    w(2);
    for (int k = 0; k < 3; k++) begin
      chk("stretch", 32'h1, tact);
      tick <= 1'b1;
      w(1);
      tick <= 1'b0;
      w(2);
    end
    chk("stretch end", 32'h0, tact);
    wb(1'b1, 8'h0C, 32'h0000_0001);
    wb(1'b1, 8'h04, 32'h8000_0000);
    w(3);
    chk("hold undriven", 32'h3F, pins.oe_n);
    wb(1'b1, 8'h08, 32'h0000_0020);
    w(2);
    chk("forced trigger", 32'h1, tact);
    chk("hold released", 32'h00, pins.oe_n);
    $display("done trigger");
    {cap_ne, cmp_ev, cap_ov} <= 3'b111;
    w(1);
    {cmp_ev, cap_ov} <= 2'b00;
    w(1);
    wb(1'b0, 8'h08, 32'h0000_000B);
    wb(1'b1, 8'h08, 32'h0000_0000);
    wb(1'b0, 8'h08, 32'h0000_0001);
    cap_ne <= 1'b0;
    wb(1'b1, 8'h08, 32'h0000_0004);
    cap_pin <= 1'b1;
    w(3);
    cap_pin <= 1'b0;
    chk("capture off", 32'h0, caps);
    wb(1'b1, 8'h08, 32'h0000_0000);
    cap_pin <= 1'b1;
    w(3);
    cap_pin <= 1'b0;
    chk("capture on", 32'h1, caps);
    wb(1'b1, 8'h08, 32'h0000_0010);
    w(2);
    chk("capture forced", 32'h2, caps);
    wb(1'b0, 8'h08, 32'h0000_0000);
    $display("done status");
    w(5);
    report_and_stop();
  end
endmodule : test_ccp_output_shutdown_control
`default_nettype wire
